// *** core/nrc_host.sv ***
// Host controller that drives the clock-SRAM socket over its SRAM pins
`timescale 1ns/1ps
`include "nrc_map.svh"

module nrc_host
  import nrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output nrc_pins_t pins,
  input wire logic [7:0] dq_in,
  output logic tk_abort_n
);

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOV} nrc_state_t;
  typedef enum logic [1:0] {PH_MEM, PH_START, PH_MATCH, PH_XFER} nrc_phase_t;

  localparam logic [63:0] UNLOCK = `NRC_UNLOCK_PAT;

  nrc_state_t st_q;
  nrc_phase_t ph_q;
  nrc_op_t op_q;
  logic [3:0] tmr_q;
  logic [6:0] cnt_q;
  logic [12:0] addr_q;
  logic [12:0] scratch_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [63:0] tk_q;
  logic done_q;
  logic abort_q;
  logic [31:0] rdat_q;
  logic go;
  logic cyc_wr;
  logic cyc_end;
  logic seq_end;
  logic [7:0] cyc_data;
  logic [12:0] cyc_addr;

  // ==========================================================
  // Software command decode
  assign go = sw_wr && (sw_addr == `NRC_REG_CMD) && sw_wdata[`NRC_CMD_GO_BIT] && (st_q == ST_IDLE);

  // Current bus cycle kind, data and address
  always_comb begin
    cyc_wr = 1'b0;
    cyc_data = wdata_q;
    cyc_addr = addr_q;
    case (ph_q)
      PH_MEM: begin
        cyc_wr = (op_q == NRC_OP_MEM_WR);
      end
      PH_START: begin
        cyc_addr = scratch_q;
      end
      PH_MATCH: begin
        cyc_wr = 1'b1;
        cyc_data = {7'h00, UNLOCK[cnt_q[5:0]]};
        cyc_addr = scratch_q;
      end
      default: begin
        cyc_wr = (op_q == NRC_OP_TK_WR);
        cyc_data = {7'h00, tk_q[0]};
        cyc_addr = scratch_q;
      end
    endcase
  end

  assign cyc_end = (st_q == ST_RECOV) && (tmr_q == 4'd1);
  assign seq_end = cyc_end && ((ph_q == PH_MEM) || ((ph_q == PH_XFER) && (cnt_q == `NRC_XFER_BITS - 7'd1)));

  // ==========================================================
  // Bus cycle sequencer: setup, strobe, recovery
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      tmr_q <= 4'd0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            st_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          st_q <= ST_STROBE;
          tmr_q <= cyc_wr ? `NRC_WP_CYC : `NRC_ACC_CYC;
        end
        ST_STROBE: begin
          if (tmr_q == 4'd1) begin
            st_q <= ST_RECOV;
            tmr_q <= `NRC_WR_CYC;
          end else begin
            tmr_q <= tmr_q - 4'd1;
          end
        end
        default: begin
          if (tmr_q == 4'd1) begin
            st_q <= seq_end ? ST_IDLE : ST_SETUP;
          end else begin
            tmr_q <= tmr_q - 4'd1;
          end
        end
      endcase
    end
  end

  // Phase walk: start read, 64 unlock writes, 64 transfers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= PH_MEM;
      cnt_q <= 7'd0;
      op_q <= NRC_OP_MEM_RD;
    end else if (go) begin
      op_q <= nrc_op_t'(sw_wdata[1:0]);
      ph_q <= sw_wdata[1] ? PH_START : PH_MEM;
      cnt_q <= 7'd0;
    end else if (cyc_end) begin
      case (ph_q)
        PH_START: begin
          ph_q <= PH_MATCH;
          cnt_q <= 7'd0;
        end
        PH_MATCH: begin
          if (cnt_q == `NRC_XFER_BITS - 7'd1) begin
            ph_q <= PH_XFER;
            cnt_q <= 7'd0;
          end else begin
            cnt_q <= cnt_q + 7'd1;
          end
        end
        PH_XFER: begin
          cnt_q <= cnt_q + 7'd1;
        end
        default: begin
          cnt_q <= 7'd0;
        end
      endcase
    end
  end

  // Data capture at the last strobe cycle, timekeeping bits rotate through
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      tk_q <= 64'h0;
    end else if (st_q == ST_IDLE && sw_wr && sw_addr == `NRC_REG_TK_LO) begin
      tk_q[31:0] <= sw_wdata;
    end else if (st_q == ST_IDLE && sw_wr && sw_addr == `NRC_REG_TK_HI) begin
      tk_q[63:32] <= sw_wdata;
    end else if (st_q == ST_STROBE && tmr_q == 4'd1 && !cyc_wr) begin
      // Read data sampled on the last strobe edge
      if (ph_q == PH_MEM) begin
        rdata_q <= dq_in;
      end else if (ph_q == PH_XFER) begin
        tk_q <= {dq_in[0], tk_q[63:1]};
      end
    end else if (cyc_end && cyc_wr && ph_q == PH_XFER) begin
      // Write bit rotates after recovery, so it still holds past the rising strobe
      tk_q <= {tk_q[0], tk_q[63:1]};
    end
  end

  // Software-written settings, taken only while idle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 13'h0000;
      wdata_q <= 8'h00;
      scratch_q <= `NRC_SCRATCH_RST;
      abort_q <= `NRC_ABORT_RST;
    end else if (sw_wr && st_q == ST_IDLE) begin
      if (sw_addr == `NRC_REG_ADDR) begin
        addr_q <= sw_wdata[12:0];
      end else if (sw_addr == `NRC_REG_WDATA) begin
        wdata_q <= sw_wdata[7:0];
      end else if (sw_addr == `NRC_REG_SCRATCH) begin
        scratch_q <= sw_wdata[12:0];
      end else if (sw_addr == `NRC_REG_CMD) begin
        abort_q <= sw_wdata[`NRC_CMD_ABORT_BIT];
      end
    end
  end

  // Done flag: completion wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (seq_end) begin
      done_q <= 1'b1;
    end else if (sw_wr && sw_addr == `NRC_REG_STATUS && sw_wdata[`NRC_STS_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdat_q <= 32'h0;
    end else if (sw_rd) begin
      if (sw_addr == `NRC_REG_CMD) begin
        rdat_q <= {27'h0, abort_q, 1'b0, 1'b0, op_q};
      end else if (sw_addr == `NRC_REG_ADDR) begin
        rdat_q <= {19'h0, addr_q};
      end else if (sw_addr == `NRC_REG_WDATA) begin
        rdat_q <= {24'h0, wdata_q};
      end else if (sw_addr == `NRC_REG_RDATA) begin
        rdat_q <= {24'h0, rdata_q};
      end else if (sw_addr == `NRC_REG_STATUS) begin
        rdat_q <= {30'h0, done_q, st_q != ST_IDLE};
      end else if (sw_addr == `NRC_REG_SCRATCH) begin
        rdat_q <= {19'h0, scratch_q};
      end else if (sw_addr == `NRC_REG_TK_LO) begin
        rdat_q <= tk_q[31:0];
      end else if (sw_addr == `NRC_REG_TK_HI) begin
        rdat_q <= tk_q[63:32];
      end else begin
        rdat_q <= 32'h0;
      end
    end else begin
      rdat_q <= 32'h0;
    end
  end

  assign sw_rdata = rdat_q;
  assign tk_abort_n = abort_q;

  // ==========================================================
  // Socket pins: address held through the whole cycle
  always_comb begin
    pins.chip_sel_n = !(st_q == ST_SETUP || st_q == ST_STROBE);
    pins.wr_strobe_n = !(st_q == ST_STROBE && cyc_wr);
    pins.out_en_n = !(st_q == ST_STROBE && !cyc_wr);
    pins.byte_address_lines = (st_q == ST_IDLE) ? 13'h0000 : cyc_addr;
    pins.dq_out = (st_q == ST_IDLE) ? 8'h00 : cyc_data;
    pins.dq_oe_n = !(st_q != ST_IDLE && cyc_wr);
  end

  // ==========================================================
  // Checks
  a_addr_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q != ST_IDLE && $past(st_q) != ST_IDLE) |-> $stable(pins.byte_address_lines))
    else $error("address moved inside a bus cycle");
  a_we_recovery: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pins.wr_strobe_n) |-> pins.wr_strobe_n && pins.chip_sel_n)
    else $error("write strobe recovery skipped");
  // Write data must outlast the rising strobe by the recovery cycle
  a_wdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pins.wr_strobe_n) |-> ($stable(pins.dq_out) && !pins.dq_oe_n))
    else $error("write data changed at the rising write strobe");
  a_oe_quiet_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!pins.wr_strobe_n || !pins.dq_oe_n) |-> pins.out_en_n)
    else $error("output enable low while host drives data");
  a_scratch_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ph_q == PH_MATCH && !pins.chip_sel_n) |-> pins.byte_address_lines == scratch_q)
    else $error("unlock write off the scratch byte");
  a_pattern_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ph_q == PH_MATCH && !pins.wr_strobe_n) |-> pins.dq_out[0] == UNLOCK[cnt_q[5:0]])
    else $error("unlock bit differs from pattern");
  a_xfer_one_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ph_q == PH_XFER && st_q == ST_STROBE) |-> (pins.out_en_n != pins.wr_strobe_n))
    else $error("transfer cycle without exactly one strobe");
  a_start_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ph_q == PH_START && st_q == ST_STROBE) |-> !pins.out_en_n ##1 ph_q == PH_START)
    else $error("unlock not opened by a read");
  a_full_groups: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ph_q == PH_XFER && $fell(st_q != ST_IDLE)) |-> $past(cnt_q) == `NRC_XFER_BITS - 7'd1)
    else $error("timekeeping transfer ended short of 64 bits");

endmodule : nrc_host

// *** core/nrc_map.svh ***
// Address map, field positions, reset values and timing counts of the clock-SRAM host
`ifndef NRC_MAP_SVH
`define NRC_MAP_SVH

// ==========================================================
// Software register offsets
`define NRC_REG_CMD     8'h00
`define NRC_REG_ADDR    8'h04
`define NRC_REG_WDATA   8'h08
`define NRC_REG_RDATA   8'h0c
`define NRC_REG_STATUS  8'h10
`define NRC_REG_SCRATCH 8'h14
`define NRC_REG_TK_LO   8'h18
`define NRC_REG_TK_HI   8'h1c

// ==========================================================
// Field positions
`define NRC_CMD_GO_BIT    2
`define NRC_CMD_ABORT_BIT 4
`define NRC_STS_BUSY_BIT  0
`define NRC_STS_DONE_BIT  1

// ==========================================================
// Reset values
`define NRC_SCRATCH_RST 13'h1fff
`define NRC_ABORT_RST   1'b1

// ==========================================================
// Unlock pattern, bytes c5 3a a3 5c twice, sent from bit 0 upward
`define NRC_UNLOCK_PAT 64'h5ca33ac5_5ca33ac5
`define NRC_XFER_BITS  7'd64

// ==========================================================
// Timing: times in ns, clock in MHz, least times rounded up
`define NRC_CLK_MHZ 10
`define NRC_T_WP_NS 150
`define NRC_T_ACC_NS 200
`define NRC_T_WR_NS 20
`define NRC_CYC(ns) ((((ns) * `NRC_CLK_MHZ) + 999) / 1000)
`define NRC_WP_CYC 4'(`NRC_CYC(`NRC_T_WP_NS))
`define NRC_ACC_CYC 4'(`NRC_CYC(`NRC_T_ACC_NS))
`define NRC_WR_CYC 4'(`NRC_CYC(`NRC_T_WR_NS))

`endif

// *** core/nrc_pkg.sv ***
// Types shared by the clock-SRAM host controller
package nrc_pkg;

  // ==========================================================
  // Commands written to the command register
  typedef enum logic [1:0] {
    NRC_OP_MEM_RD,
    NRC_OP_MEM_WR,
    NRC_OP_TK_RD,
    NRC_OP_TK_WR
  } nrc_op_t;

  // ==========================================================
  // Pins driven towards the memory socket
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic wr_strobe_n;
    logic [12:0] byte_address_lines;
    logic [7:0] dq_out;
    logic dq_oe_n;
  } nrc_pins_t;

endpackage : nrc_pkg

// *** tb/nrc_dev_model.sv ***
// Behavioural clock-SRAM device seen from the host socket
`timescale 1ns/1ps
module nrc_dev_model
  import nrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input nrc_pins_t pins,
  input wire logic [7:0] dq_wire,
  input wire logic abort_n,
  output logic [7:0] dev_dq,
  output logic dev_drv,
  output logic [7:0] viol
);
  localparam logic [63:0] UNLOCK = 64'h5ca33ac5_5ca33ac5;
  logic [7:0] mem [0:8191];
  logic [63:0] tk;
  logic [63:0] tk_new;
  logic [5:0] ptr;
  logic [5:0] xcnt;
  logic fail;
  logic on;
  nrc_pins_t prev;
  // ==========================================================
  // Device drives data while selected, read enabled and strobe high
  assign dev_drv = !pins.chip_sel_n && !pins.out_en_n && pins.wr_strobe_n;
  // Cycle decode, unlock recognition and serial transfer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= '0;
      xcnt <= '0;
      fail <= 1'b1;
      on <= 1'b0;
      viol <= '0;
      prev <= '1;
      tk <= 64'h0;
      dev_dq <= 8'h00;
    end else begin
      prev <= pins;
      // Host moving address in a cycle or enabling output during a write
      viol <= viol + 8'((!pins.chip_sel_n && !prev.chip_sel_n &&
        pins.byte_address_lines !== prev.byte_address_lines) || (!pins.out_en_n && !pins.wr_strobe_n));
      // Only chip-selected cycles count, so other devices' cycles pass untouched
      if (!pins.chip_sel_n && !pins.out_en_n && prev.out_en_n) begin
        if (on) begin
          dev_dq <= {7'h00, tk[xcnt]};
          xcnt <= xcnt + 6'h01;
          on <= (xcnt != 6'h3f);
        end else begin
          dev_dq <= mem[pins.byte_address_lines];
          ptr <= '0;
          fail <= 1'b0;
        end
      end
      // Write ends at the rising strobe
      if (pins.wr_strobe_n && !prev.wr_strobe_n && !prev.chip_sel_n) begin
        if (on) begin
          tk_new[xcnt] <= dq_wire[0];
          xcnt <= xcnt + 6'h01;
          if (xcnt == 6'h3f) begin
            on <= 1'b0;
            tk <= {dq_wire[0], tk_new[62:0]};
          end
        end else begin
          mem[prev.byte_address_lines] <= dq_wire;
          if (!fail && dq_wire[0] == UNLOCK[ptr]) begin
            ptr <= ptr + 6'h01;
            on <= (ptr == 6'h3f);
            fail <= (ptr == 6'h3f);
            xcnt <= '0;
          end else begin
            fail <= 1'b1;
          end
        end
      end
      // Abort pin ends a transfer when the day register allows it
      if (on && !abort_n && !tk[36]) begin
        on <= 1'b0;
        fail <= 1'b1;
      end
    end
  end
endmodule : nrc_dev_model

// *** tb/tb.sv ***
// Self-checking bench for the clock-SRAM host controller
`timescale 1ns/1ps
`include "nrc_map.svh"
module tb
  import nrc_pkg::*;
;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 0;
  logic sw_rd = 0;
  logic [31:0] sw_rdata;
  nrc_pins_t pins;
  logic tk_abort_n;
  logic [7:0] dev_dq;
  logic dev_drv;
  logic [7:0] viol;
  logic [7:0] dq_w;
  logic [7:0] dq_last = 8'h00;
  int bad_count = 0;
  int n_compared = 0;
  localparam logic [63:0] TKV = 64'h24051102_23301299;
  // ==========================================================
  // Clock, dq wire resolution and instances
  always #50 sys_clk = ~sys_clk;
  assign dq_w = !pins.dq_oe_n ? pins.dq_out : dev_drv ? dev_dq : ~dq_last;
  always @(posedge sys_clk) dq_last <= dq_w;
  nrc_host DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pins(pins), .dq_in(dq_w), .tk_abort_n(tk_abort_n));
  nrc_dev_model dev (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .dq_wire(dq_w), .abort_n(tk_abort_n),
    .dev_dq(dev_dq), .dev_drv(dev_drv), .viol(viol));
  // ==========================================================
  // Bus tasks
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : rd
  // Start an operation and wait for done under a bound
  task automatic run(input logic [31:0] cmd);
    logic [31:0] s;
    wr(`NRC_REG_CMD, cmd);
    rd(`NRC_REG_STATUS, s);
    chk("busy", 64'h1, 64'(s[1:0]));
    for (int i = 0; i < 400 && !s[`NRC_STS_DONE_BIT]; i++) rd(`NRC_REG_STATUS, s);
    chk("done", 64'h1, 64'(s[`NRC_STS_DONE_BIT]));
    wr(`NRC_REG_STATUS, 32'h2);
  endtask : run
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] d;
    rd(`NRC_REG_SCRATCH, d);
    chk("scratch", 64'h1fff, 64'(d));
    rd(`NRC_REG_CMD, d);
    chk("cmd", 64'h10, 64'(d));
    rd(8'h20, d);
    chk("unmapped", 64'h0, 64'(d));
  endtask : t_regs
  task automatic t_mem();
    logic [31:0] d;
    wr(`NRC_REG_ADDR, 32'h1abc);
    wr(`NRC_REG_WDATA, 32'ha5);
    rd(`NRC_REG_ADDR, d);
    chk("addr", 64'h1abc, 64'(d));
    rd(`NRC_REG_WDATA, d);
    chk("wdata", 64'ha5, 64'(d));
    run(32'h14 | 32'(NRC_OP_MEM_WR));
    chk("mem", 64'ha5, 64'(dev.mem[13'h1abc]));
    run(32'h14 | 32'(NRC_OP_MEM_RD));
    rd(`NRC_REG_RDATA, d);
    chk("rdata", 64'ha5, 64'(d));
  endtask : t_mem
  task automatic t_clock();
    logic [31:0] lo;
    logic [31:0] hi;
    wr(`NRC_REG_SCRATCH, 32'h0010);
    wr(`NRC_REG_TK_LO, TKV[31:0]);
    wr(`NRC_REG_TK_HI, TKV[63:32]);
    run(32'h14 | 32'(NRC_OP_TK_WR));
    chk("tk", TKV, dev.tk);
    chk("user byte", 64'ha5, 64'(dev.mem[13'h1abc]));
    wr(`NRC_REG_TK_LO, 32'h0);
    wr(`NRC_REG_TK_HI, 32'h0);
    run(32'h14 | 32'(NRC_OP_TK_RD));
    rd(`NRC_REG_TK_LO, lo);
    rd(`NRC_REG_TK_HI, hi);
    chk("tk read", TKV, {hi, lo});
    run(32'h04 | 32'(NRC_OP_TK_RD));
    chk("abort pin", 64'h0, 64'(tk_abort_n));
    chk("aborted tk", TKV, dev.tk);
    rd(`NRC_REG_TK_LO, lo);
    rd(`NRC_REG_TK_HI, hi);
    chk("aborted read", 64'h0, {hi, lo});
    chk("host order", 64'h0, 64'(viol));
  endtask : t_clock
  // ==========================================================
  // Verdict and watchdog
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_mem();
    t_clock();
    close_out();
  end
endmodule : tb
